/* File: common/tcc_pkg.sv */
// constants for the 16-bit capture/compare timer: register map, field
// positions, reset values and prescaler figures.
// assumes a 32-bit avalon-mm slave with each byte register in one word.
package tcc_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_CONTROL_ONE = 6'h00;
  localparam logic [5:0] ADDR_CONTROL_TWO = 6'h04;
  localparam logic [5:0] ADDR_FLAGS = 6'h08;
  localparam logic [5:0] ADDR_COUNT_HIGH = 6'h0C;
  localparam logic [5:0] ADDR_COUNT_LOW = 6'h10;
  localparam logic [5:0] ADDR_ALT_HIGH = 6'h14;
  localparam logic [5:0] ADDR_ALT_LOW = 6'h18;
  localparam logic [5:0] ADDR_CAP1_HIGH = 6'h1C;
  localparam logic [5:0] ADDR_CAP1_LOW = 6'h20;
  localparam logic [5:0] ADDR_CAP2_HIGH = 6'h24;
  localparam logic [5:0] ADDR_CAP2_LOW = 6'h28;
  localparam logic [5:0] ADDR_CMP1_HIGH = 6'h2C;
  localparam logic [5:0] ADDR_CMP1_LOW = 6'h30;
  localparam logic [5:0] ADDR_CMP2_HIGH = 6'h34;
  localparam logic [5:0] ADDR_CMP2_LOW = 6'h38;
  // ----------------------------------------------------------------
  // control_one fields
  // ----------------------------------------------------------------
  localparam int C1_CAP_IRQ_EN = 7;
  localparam int C1_CMP_IRQ_EN = 6;
  localparam int C1_OVF_IRQ_EN = 5;
  localparam int C1_CAP_EDGE1 = 2;
  localparam int C1_OUT_LEVEL2 = 1;
  localparam int C1_OUT_LEVEL1 = 0;
  // ----------------------------------------------------------------
  // control_two fields
  // ----------------------------------------------------------------
  localparam int C2_PIN_EN1 = 7;
  localparam int C2_PIN_EN2 = 6;
  localparam int C2_ONE_PULSE = 5;
  localparam int C2_PWM = 4;
  localparam int C2_CLK_SEL_HI = 3;
  localparam int C2_CLK_SEL_LO = 2;
  localparam int C2_CAP_EDGE2 = 1;
  localparam int C2_EXT_EDGE = 0;
  // ----------------------------------------------------------------
  // timer_flags_register fields
  // ----------------------------------------------------------------
  localparam int F_CAP1 = 7;
  localparam int F_CMP1 = 6;
  localparam int F_OVF = 5;
  localparam int F_CAP2 = 4;
  localparam int F_CMP2 = 3;
  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_PRESET = 16'hFFFC;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [1:0] SEL_DIV4 = 2'h0;
  localparam logic [1:0] SEL_DIV2 = 2'h1;
  localparam logic [1:0] SEL_DIV8 = 2'h2;
  localparam logic [1:0] SEL_EXT = 2'h3;
  localparam logic [2:0] PRESC_END_DIV2 = 3'h1;
  localparam logic [2:0] PRESC_END_DIV4 = 3'h3;
  localparam logic [2:0] PRESC_END_DIV8 = 3'h7;
endpackage

/* File: design/tcc_timer.sv */
// 16-bit free-running timer with two capture and two compare channels.
// assumes an avalon-mm master on clk_sys; input pins are asynchronous and pass through three-stage synchronisers.
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module tcc_timer (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic globalMask,
  input wire logic haltMode,
  input wire logic extTimerClockPin,
  input wire logic [1:0] captureInputPin,
  output logic [1:0] compareOutputPin,
  output logic timerIrq
);
  typedef struct packed {
    logic waitReq;
    logic [31:0] rdata;
    logic [7:0] controlOne;
    logic [7:0] controlTwo;
    logic [15:0] count;
    logic [2:0] presc;
    logic [2:0] extSync;
    logic [1:0][2:0] capSync;
    logic [7:0] lowBuf;
    logic cntLatched;
    logic overflowFlag;
    logic [1:0] captureFlag;
    logic [1:0] compareFlag;
    logic armOvf;
    logic [1:0] armCap;
    logic [1:0] armCmp;
    logic [1:0][15:0] captureValue;
    logic [1:0] capHold;
    logic [1:0][15:0] compareValue;
    logic [1:0] cmpHold;
    logic [1:0] pin;
    logic irq;
  } tcc_state_t;

  tcc_state_t st;
  tcc_state_t next_st;

  // edge seen between the second and third synchroniser stages
  function automatic logic syncEdge(input logic s2, input logic s3, input logic rising);
    syncEdge = rising ? (s2 && !s3) : (!s2 && s3);
  endfunction

  logic accept;
  logic rd;
  logic wr;
  logic tick;
  logic [15:0] countInc;
  logic [1:0] capEvent;
  logic [1:0] capEdgeSel;
  logic [1:0] cmpMatch;
  logic [1:0] clockSel;
  logic [2:0] prescEnd;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    accept = (read || write) && !st.waitReq;
    rd = read && accept;
    wr = write && accept && byteenable[0];
    clockSel = st.controlTwo[tcc_pkg::C2_CLK_SEL_HI:tcc_pkg::C2_CLK_SEL_LO];
    unique case (clockSel)
      tcc_pkg::SEL_DIV2: prescEnd = tcc_pkg::PRESC_END_DIV2;
      tcc_pkg::SEL_DIV8: prescEnd = tcc_pkg::PRESC_END_DIV8;
      default: prescEnd = tcc_pkg::PRESC_END_DIV4;
    endcase

    // bus handshake: one wait cycle, then the access is taken
    next_st.waitReq = !((read || write) && st.waitReq);

    // synchronisers; first stage feeds only the second
    next_st.extSync = {st.extSync[1:0], extTimerClockPin};
    for (int i = 0; i < 2; i++) begin
      next_st.capSync[i] = {st.capSync[i][1:0], captureInputPin[i]};
    end

    // timer clock; halt freezes prescaler and count
    if (clockSel == tcc_pkg::SEL_EXT) begin
      tick = !haltMode && syncEdge(st.extSync[1], st.extSync[2],
                                   st.controlTwo[tcc_pkg::C2_EXT_EDGE]);
    end else begin
      tick = !haltMode && ((st.presc & prescEnd) == prescEnd);
    end
    if (!haltMode) begin
      next_st.presc = st.presc + 3'h1;
    end
    countInc = st.count + 16'h0001;
    if (tick) begin
      next_st.count = countInc;
    end

    // compare: match on the counter value about to be entered
    capEdgeSel = {st.controlTwo[tcc_pkg::C2_CAP_EDGE2], st.controlOne[tcc_pkg::C1_CAP_EDGE1]};
    for (int i = 0; i < 2; i++) begin
      cmpMatch[i] = tick && !st.cmpHold[i] && (countInc == st.compareValue[i]);
      capEvent[i] = !st.capHold[i]
                    && syncEdge(st.capSync[i][1], st.capSync[i][2], capEdgeSel[i]);
    end
    capEvent[0] = capEvent[0] && !st.controlTwo[tcc_pkg::C2_ONE_PULSE]
                  && !st.controlTwo[tcc_pkg::C2_PWM];

    // flags-register read arms the clear for flags then set
    if (rd && address == tcc_pkg::ADDR_FLAGS) begin
      if (st.overflowFlag) begin
        next_st.armOvf = 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
        if (st.captureFlag[i]) begin
          next_st.armCap[i] = 1'b1;
        end
        if (st.compareFlag[i]) begin
          next_st.armCmp[i] = 1'b1;
        end
      end
    end

    // read data, loaded in the wait cycle
    next_st.rdata = 32'h0000_0000;
    if (read && st.waitReq) begin
      unique case (address)
        tcc_pkg::ADDR_CONTROL_ONE: next_st.rdata[7:0] = st.controlOne;
        tcc_pkg::ADDR_CONTROL_TWO: next_st.rdata[7:0] = st.controlTwo;
        tcc_pkg::ADDR_FLAGS: begin
          next_st.rdata[tcc_pkg::F_OVF] = st.overflowFlag;
          next_st.rdata[tcc_pkg::F_CAP1] = st.captureFlag[0];
          next_st.rdata[tcc_pkg::F_CAP2] = st.captureFlag[1];
          next_st.rdata[tcc_pkg::F_CMP1] = st.compareFlag[0];
          next_st.rdata[tcc_pkg::F_CMP2] = st.compareFlag[1];
        end
        tcc_pkg::ADDR_COUNT_HIGH, tcc_pkg::ADDR_ALT_HIGH: begin
          next_st.rdata[7:0] = st.count[15:8];
          // low byte taken with the high byte so the pair is one coherent count
          if (!st.cntLatched) begin
            next_st.lowBuf = st.count[7:0];
          end
        end
        tcc_pkg::ADDR_COUNT_LOW, tcc_pkg::ADDR_ALT_LOW: begin
          next_st.rdata[7:0] = st.cntLatched ? st.lowBuf : st.count[7:0];
        end
        tcc_pkg::ADDR_CAP1_HIGH: next_st.rdata[7:0] = st.captureValue[0][15:8];
        tcc_pkg::ADDR_CAP1_LOW: next_st.rdata[7:0] = st.captureValue[0][7:0];
        tcc_pkg::ADDR_CAP2_HIGH: next_st.rdata[7:0] = st.captureValue[1][15:8];
        tcc_pkg::ADDR_CAP2_LOW: next_st.rdata[7:0] = st.captureValue[1][7:0];
        tcc_pkg::ADDR_CMP1_HIGH: next_st.rdata[7:0] = st.compareValue[0][15:8];
        tcc_pkg::ADDR_CMP1_LOW: next_st.rdata[7:0] = st.compareValue[0][7:0];
        tcc_pkg::ADDR_CMP2_HIGH: next_st.rdata[7:0] = st.compareValue[1][15:8];
        tcc_pkg::ADDR_CMP2_LOW: next_st.rdata[7:0] = st.compareValue[1][7:0];
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end

    // counter high/low read pairing; low buffer frozen once taken
    if (rd && (address == tcc_pkg::ADDR_COUNT_HIGH || address == tcc_pkg::ADDR_ALT_HIGH)) begin
      next_st.cntLatched = 1'b1;
    end
    if ((rd || wr) && (address == tcc_pkg::ADDR_COUNT_LOW || address == tcc_pkg::ADDR_ALT_LOW)) begin
      next_st.cntLatched = 1'b0;
      if (wr) begin
        next_st.count = tcc_pkg::COUNT_PRESET;
        next_st.presc = 3'h0;
      end
    end

    // overflow clear; alternate low never clears it
    if ((rd || wr) && address == tcc_pkg::ADDR_COUNT_LOW && st.armOvf) begin
      next_st.overflowFlag = 1'b0;
      next_st.armOvf = 1'b0;
    end
    if (tick && st.count == tcc_pkg::COUNT_MAX && !(wr && address == tcc_pkg::ADDR_COUNT_LOW)) begin
      next_st.overflowFlag = 1'b1;
    end
    if (wr && address == tcc_pkg::ADDR_ALT_LOW && tick && st.count == tcc_pkg::COUNT_MAX) begin
      next_st.overflowFlag = 1'b1;
    end

    // capture channels
    for (int i = 0; i < 2; i++) begin
      if (rd && address == (i == 0 ? tcc_pkg::ADDR_CAP1_HIGH : tcc_pkg::ADDR_CAP2_HIGH)) begin
        next_st.capHold[i] = 1'b1;
      end
      if ((rd || wr) && address == (i == 0 ? tcc_pkg::ADDR_CAP1_LOW : tcc_pkg::ADDR_CAP2_LOW)) begin
        if (rd) begin
          next_st.capHold[i] = 1'b0;
        end
        if (st.armCap[i]) begin
          next_st.captureFlag[i] = 1'b0;
          next_st.armCap[i] = 1'b0;
        end
      end
      if (capEvent[i]) begin
        next_st.captureValue[i] = st.count;
        next_st.captureFlag[i] = 1'b1;
      end
    end

    // compare channels
    for (int i = 0; i < 2; i++) begin
      if (wr && address == (i == 0 ? tcc_pkg::ADDR_CMP1_HIGH : tcc_pkg::ADDR_CMP2_HIGH)) begin
        next_st.compareValue[i][15:8] = writedata[7:0];
        next_st.cmpHold[i] = 1'b1;
      end
      if ((rd || wr) && address == (i == 0 ? tcc_pkg::ADDR_CMP1_LOW : tcc_pkg::ADDR_CMP2_LOW)) begin
        if (wr) begin
          next_st.compareValue[i][7:0] = writedata[7:0];
          next_st.cmpHold[i] = 1'b0;
        end
        if (st.armCmp[i]) begin
          next_st.compareFlag[i] = 1'b0;
          next_st.armCmp[i] = 1'b0;
        end
      end
      if (cmpMatch[i]) begin
        next_st.compareFlag[i] = 1'b1;
        if (st.controlTwo[i == 0 ? tcc_pkg::C2_PIN_EN1 : tcc_pkg::C2_PIN_EN2]) begin
          next_st.pin[i] = st.controlOne[i == 0 ? tcc_pkg::C1_OUT_LEVEL1 : tcc_pkg::C1_OUT_LEVEL2];
        end
      end
    end

    // control writes
    if (wr && address == tcc_pkg::ADDR_CONTROL_ONE) begin
      next_st.controlOne = writedata[7:0];
    end
    if (wr && address == tcc_pkg::ADDR_CONTROL_TWO) begin
      next_st.controlTwo = writedata[7:0];
    end

    // pending flags stay set, so a masked request fires once unmasked
    next_st.irq = !globalMask && (
      (st.overflowFlag && st.controlOne[tcc_pkg::C1_OVF_IRQ_EN])
      || ((|st.captureFlag) && st.controlOne[tcc_pkg::C1_CAP_IRQ_EN])
      || ((|st.compareFlag) && st.controlOne[tcc_pkg::C1_CMP_IRQ_EN]));
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.waitReq <= 1'b1;
      st.controlOne <= tcc_pkg::CTL_RESET;
      st.controlTwo <= tcc_pkg::CTL_RESET;
      st.count <= tcc_pkg::COUNT_PRESET;
      st.compareValue <= {tcc_pkg::CMP_RESET, tcc_pkg::CMP_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign readdata = st.rdata;
  assign waitrequest = st.waitReq;
  assign compareOutputPin = st.pin;
  assign timerIrq = st.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  property p_ovfSet;
    tick && st.count == tcc_pkg::COUNT_MAX
      && !(wr && (address == tcc_pkg::ADDR_COUNT_LOW || address == tcc_pkg::ADDR_ALT_LOW))
      |=> st.overflowFlag && st.count == 16'h0000;
  endproperty
  a_ovfSet: assert property (p_ovfSet) else $error("overflow flag not set on wrap");

  property p_ovfClear;
    st.armOvf && rd && address == tcc_pkg::ADDR_COUNT_LOW && !tick |=> !st.overflowFlag;
  endproperty
  a_ovfClear: assert property (p_ovfClear) else $error("overflow flag not cleared");

  property p_lowFrozen;
    st.cntLatched && !(accept && (address == tcc_pkg::ADDR_COUNT_LOW
      || address == tcc_pkg::ADDR_ALT_LOW)) |=> $stable(st.lowBuf) && st.cntLatched;
  endproperty
  a_lowFrozen: assert property (p_lowFrozen) else $error("low buffer moved");

  property p_altKeepsOvf;
    st.overflowFlag && accept && address == tcc_pkg::ADDR_ALT_LOW |=> st.overflowFlag;
  endproperty
  a_altKeepsOvf: assert property (p_altKeepsOvf) else $error("alt low cleared flag");

  property p_lowWriteReload;
    wr && address == tcc_pkg::ADDR_COUNT_LOW |=> st.count == tcc_pkg::COUNT_PRESET;
  endproperty
  a_lowWriteReload: assert property (p_lowWriteReload) else $error("no preset reload");

  property p_haltHolds;
    haltMode && !wr |=> $stable(st.count);
  endproperty
  a_haltHolds: assert property (p_haltHolds) else $error("count moved in halt");

  property p_capHold;
    st.capHold[1] && !(rd && address == tcc_pkg::ADDR_CAP2_LOW) |=> $stable(st.captureValue[1]);
  endproperty
  a_capHold: assert property (p_capHold) else $error("capture while held");

  property p_cap1Off;
    st.controlTwo[tcc_pkg::C2_PWM] |=> $stable(st.captureValue[0]);
  endproperty
  a_cap1Off: assert property (p_cap1Off) else $error("capture one in pwm");

  property p_cmpHold;
    st.cmpHold[0] && !st.compareFlag[0] |=> !st.compareFlag[0];
  endproperty
  a_cmpHold: assert property (p_cmpHold) else $error("compare while suspended");

  property p_cmpPin;
    cmpMatch[0] && st.controlTwo[tcc_pkg::C2_PIN_EN1]
      |=> compareOutputPin[0] == $past(st.controlOne[tcc_pkg::C1_OUT_LEVEL1])
      && st.compareFlag[0];
  endproperty
  a_cmpPin: assert property (p_cmpPin) else $error("compare match missed");

  property p_irqMasked;
    globalMask |=> !timerIrq;
  endproperty
  a_irqMasked: assert property (p_irqMasked) else $error("irq while masked");

  property p_irqCombine;
    !globalMask && ((st.overflowFlag && st.controlOne[tcc_pkg::C1_OVF_IRQ_EN])
      || (st.captureFlag[1] && st.controlOne[tcc_pkg::C1_CAP_IRQ_EN])
      || (st.compareFlag[1] && st.controlOne[tcc_pkg::C1_CMP_IRQ_EN])) |=> timerIrq;
  endproperty
  a_irqCombine: assert property (p_irqCombine) else $error("request not combined");

  property p_div2Rate;
    clockSel == tcc_pkg::SEL_DIV2 && !haltMode && tick
      && !(wr && address == tcc_pkg::ADDR_CONTROL_TWO) |=> !tick;
  endproperty
  a_div2Rate: assert property (p_div2Rate) else $error("div2 ticks too fast");

  property p_waitOne;
    read && st.waitReq |=> !waitrequest;
  endproperty
  a_waitOne: assert property (p_waitOne) else $error("read not answered");

  c_overflow: cover property (tick && st.count == tcc_pkg::COUNT_MAX);
  c_capture: cover property (capEvent[1]);
  c_compare: cover property (cmpMatch[0] && st.controlTwo[tcc_pkg::C2_PIN_EN1]);
  c_irq: cover property (timerIrq);
  c_extTick: cover property (tick && clockSel == tcc_pkg::SEL_EXT);
endmodule

/* File: bench/tcc_pin_model.sv */
// far-side model: external timer clock source and the two capture inputs.
// assumes the bench calls its tasks and that clk_sys is the cpu clock.
`timescale 1ns/10ps
module tcc_pin_model (
  input wire logic clk_sys,
  output logic extTimerClockPin,
  output logic [1:0] captureInputPin
);
  initial begin
    extTimerClockPin = 1'h0;
    captureInputPin = 2'h0;
  end
  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  // eleven cpu clocks per period: well under a quarter of the cpu rate
  task automatic ext_edges(input int n);
    repeat (n) begin
      @(posedge clk_sys) extTimerClockPin <= 1'h1;
      repeat (5) @(posedge clk_sys);
      extTimerClockPin <= 1'h0;
      repeat (5) @(posedge clk_sys);
    end
  endtask
  // one rising then one falling transition, each long enough to be synchronised
  task automatic cap_pulse(input int ch);
    repeat (2) begin
      @(posedge clk_sys) captureInputPin[ch] <= !captureInputPin[ch];
      repeat (6) @(posedge clk_sys);
    end
  endtask
endmodule

/* File: bench/tb_timer16_capture_compare.sv */
// self-checking bench for the capture/compare timer over avalon-mm.
// assumes the pin model drives the external clock and capture inputs.
`timescale 1ns/10ps
module tb_timer16_capture_compare;
  logic clk_sys, reset_n, read, write, waitrequest, globalMask, haltMode;
  logic extTimerClockPin, timerIrq;
  logic [5:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, rng;
  logic [1:0] captureInputPin, compareOutputPin;
  logic [7:0] q, l1, dd;
  logic [15:0] v, expCount;
  logic [15:0] cmpModel [2];
  logic [5:0] hi;
  int numErrors, nChecks, fb;

  tcc_timer tcc_timer_i (.clk_sys, .reset_n, .address, .read, .write, .byteenable,
    .writedata, .readdata, .waitrequest, .globalMask, .haltMode, .extTimerClockPin,
    .captureInputPin, .compareOutputPin, .timerIrq);
  tcc_pin_model tcc_pin_model_i (.clk_sys, .extTimerClockPin, .captureInputPin);

  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finishTest();
    $display("checks %0d errors %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // request held until waitrequest is seen low; data taken at that edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    address <= a;
    read <= !wr;
    write <= wr;
    // unused upper bits carry random noise the slave must ignore
    writedata <= {rng[23:0], d};
    do begin
      @(posedge clk_sys);
    end while (waitrequest !== 1'h0);
    q = readdata[7:0];
    read <= 1'h0;
    write <= 1'h0;
  endtask
  task automatic rd(input logic [5:0] a);
    bus(1'h0, a, 8'h00);
  endtask
  task automatic rd16(input logic [5:0] a);
    rd(a);
    v[15:8] = q;
    rd(a + 6'h04);
    v[7:0] = q;
  endtask
  task automatic flag(input int b, input logic e);
    rd(tcc_pkg::ADDR_FLAGS);
    check({15'h0000, q[b]}, {15'h0000, e});
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    reset_n = 1'h0;
    read = 1'h0;
    write = 1'h0;
    address = 6'h00;
    writedata = 32'h0;
    byteenable = 4'hF;
    globalMask = 1'h1;
    haltMode = 1'h1;
    numErrors = 0;
    nChecks = 0;
    rng = 32'h87E9;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'h1;
    check({14'h0000, compareOutputPin}, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      rd16(tcc_pkg::ADDR_CMP1_HIGH + 6'(8 * i));
      check(v, tcc_pkg::CMP_RESET);
    end
    rd16(tcc_pkg::ADDR_COUNT_HIGH);
    check(v, tcc_pkg::COUNT_PRESET);
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      cmpModel[i % 2] = rng[15:0];
      hi = tcc_pkg::ADDR_CMP1_HIGH + 6'(8 * (i % 2));
      bus(1'h1, hi, rng[15:8]);
      bus(1'h1, hi + 6'h04, rng[7:0]);
    end
    for (int i = 0; i < 2; i++) begin
      rd16(tcc_pkg::ADDR_CMP1_HIGH + 6'(8 * i));
      check(v, cmpModel[i]);
    end
    rd(6'h3C);
    check({8'h00, q}, 16'h0000);
    // a write without the low byte lane enabled must be ignored
    byteenable <= 4'hE;
    bus(1'h1, tcc_pkg::ADDR_CONTROL_ONE, 8'hFF);
    byteenable <= 4'hF;
    rd(tcc_pkg::ADDR_CONTROL_ONE);
    check({8'h00, q}, {8'h00, tcc_pkg::CTL_RESET});
    // buffered low byte must ignore the repeated high read
    haltMode <= 1'h0;
    bus(1'h1, tcc_pkg::ADDR_CONTROL_TWO, 8'h08);
    for (int i = 0; i < 2; i++) begin
      hi = tcc_pkg::ADDR_COUNT_HIGH + 6'(8 * i);
      rd(hi);
      repeat (40) @(posedge clk_sys);
      rd(hi);
      rd(hi + 6'h04);
      l1 = q;
      rd(hi + 6'h04);
      dd = q - l1;
      check({15'h0000, dd inside {[4:12]}}, 16'h0001);
    end
    bus(1'h1, tcc_pkg::ADDR_CONTROL_ONE, 8'h20);
    bus(1'h1, tcc_pkg::ADDR_CONTROL_TWO, 8'h04);
    rd(tcc_pkg::ADDR_FLAGS);
    bus(1'h1, tcc_pkg::ADDR_COUNT_LOW, 8'h00);
    flag(tcc_pkg::F_OVF, 1'h0);
    repeat (30) @(posedge clk_sys);
    check({15'h0000, timerIrq}, 16'h0000);
    flag(tcc_pkg::F_OVF, 1'h1);
    globalMask <= 1'h0;
    repeat (3) @(posedge clk_sys);
    check({15'h0000, timerIrq}, 16'h0001);
    rd(tcc_pkg::ADDR_ALT_LOW);
    flag(tcc_pkg::F_OVF, 1'h1);
    rd(tcc_pkg::ADDR_COUNT_LOW);
    flag(tcc_pkg::F_OVF, 1'h0);
    repeat (3) @(posedge clk_sys);
    check({15'h0000, timerIrq}, 16'h0000);
    // external clock makes the count exact, so the model tracks it
    globalMask <= 1'h1;
    bus(1'h1, tcc_pkg::ADDR_CONTROL_ONE, 8'h03);
    bus(1'h1, tcc_pkg::ADDR_CONTROL_TWO, 8'hCD);
    bus(1'h1, tcc_pkg::ADDR_COUNT_LOW, 8'h00);
    bus(1'h1, tcc_pkg::ADDR_CMP1_HIGH, 8'hFF);
    bus(1'h1, tcc_pkg::ADDR_CMP1_LOW, 8'hFE);
    bus(1'h1, tcc_pkg::ADDR_CMP2_HIGH, 8'hFF);
    bus(1'h1, tcc_pkg::ADDR_CMP2_LOW, 8'hFD);
    tcc_pin_model_i.ext_edges(2);
    expCount = 16'hFFFE;
    check({14'h0000, compareOutputPin}, 16'h0003);
    rd16(tcc_pkg::ADDR_COUNT_HIGH);
    check(v, expCount);
    flag(tcc_pkg::F_CMP1, 1'h1);
    bus(1'h1, tcc_pkg::ADDR_CMP1_LOW, 8'hFE);
    flag(tcc_pkg::F_CMP1, 1'h0);
    tcc_pin_model_i.ext_edges(2);
    flag(tcc_pkg::F_OVF, 1'h1);
    haltMode <= 1'h1;
    tcc_pin_model_i.ext_edges(2);
    rd16(tcc_pkg::ADDR_COUNT_HIGH);
    check(v, 16'h0000);
    haltMode <= 1'h0;
    bus(1'h1, tcc_pkg::ADDR_CMP2_HIGH, 8'h00);
    rd(tcc_pkg::ADDR_FLAGS);
    bus(1'h1, tcc_pkg::ADDR_CMP2_LOW, 8'h01);
    bus(1'h1, tcc_pkg::ADDR_CMP2_HIGH, 8'h00);
    tcc_pin_model_i.ext_edges(1);
    expCount = 16'h0001;
    flag(tcc_pkg::F_CMP2, 1'h0);
    // channel one rising, channel two falling, counter on falling ext edges
    bus(1'h1, tcc_pkg::ADDR_CONTROL_ONE, 8'h84);
    bus(1'h1, tcc_pkg::ADDR_CONTROL_TWO, 8'h0C);
    globalMask <= 1'h0;
    for (int c = 0; c < 2; c++) begin
      hi = tcc_pkg::ADDR_CAP1_HIGH + 6'(8 * c);
      fb = (c == 0) ? tcc_pkg::F_CAP1 : tcc_pkg::F_CAP2;
      tcc_pin_model_i.ext_edges(1);
      expCount++;
      tcc_pin_model_i.cap_pulse(c);
      check({15'h0000, timerIrq}, 16'h0001);
      flag(fb, 1'h1);
      rd16(hi);
      check(v, expCount);
      flag(fb, 1'h0);
      rd(hi);
      tcc_pin_model_i.ext_edges(1);
      expCount++;
      tcc_pin_model_i.cap_pulse(c);
      flag(fb, 1'h0);
      rd(hi + 6'h04);
      check({8'h00, q}, {8'h00, 8'(expCount - 16'h0001)});
      tcc_pin_model_i.cap_pulse(c);
      rd16(hi);
      check(v, expCount);
    end
    // pwm first, then one-pulse: each alone must disable capture one
    for (int m = 0; m < 2; m++) begin
      bus(1'h1, tcc_pkg::ADDR_CONTROL_TWO, (m == 0) ? 8'h1C : 8'h2C);
      rd(tcc_pkg::ADDR_FLAGS);
      rd(tcc_pkg::ADDR_CAP1_LOW);
      tcc_pin_model_i.cap_pulse(0);
      flag(tcc_pkg::F_CAP1, 1'h0);
    end
    // reset in mid-run: pins drop and the count restarts from the preset
    haltMode <= 1'h1;
    reset_n <= 1'h0;
    @(posedge clk_sys);
    reset_n <= 1'h1;
    check({14'h0000, compareOutputPin}, 16'h0000);
    check({15'h0000, timerIrq}, 16'h0000);
    rd16(tcc_pkg::ADDR_COUNT_HIGH);
    check(v, tcc_pkg::COUNT_PRESET);
    finishTest();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    numErrors++;
    finishTest();
  end
endmodule
